// >>> hw/gated_prescaled_timer16.sv
`timescale 1ns/1ps
`default_nettype none
module gated_prescaled_timer16 (
    input  wire logic                         clock_i,
    input  wire logic                         rst_i,
    input  wire logic                         timer_run_bit_i,
    input  wire timer_pkg::prescale_t         prescale_select_i,
    input  wire logic                         clock_source_select_i,
    input  wire logic                         gate_accumulate_enable_i,
    input  wire logic                         external_clock_sync_i,
    input  wire logic                         stop_in_idle_i,
    input  wire logic                         cpu_idle_i,
    input  wire logic                         cpu_sleep_i,
    input  wire logic                         timer_irq_enable_i,
    input  wire logic [timer_pkg::PRIO_W-1:0] timer_irq_priority_i,
    input  wire logic                         count_wr_i,
    input  wire logic [15:0]                  count_wdata_i,
    input  wire logic                         period_wr_i,
    input  wire logic [15:0]                  period_wdata_i,
    input  wire logic                         ext_clk_i,
    input  wire logic                         gate_i,
    output logic      [15:0]                  timer_count_reg_o,
    output logic      [15:0]                  timer_period_reg_o,
    output logic                              irq_o,
    output logic      [timer_pkg::PRIO_W-1:0] irq_priority_o
);
    import timer_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic gate_s1_r;
    logic gate_s2_r;
    logic gate_s3_r;

    // The third stage only feeds edge detection; the first stage is never decoded.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk_i;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gate_s1_r <= 1'b0;
            gate_s2_r <= 1'b0;
            gate_s3_r <= 1'b0;
        end else begin
            gate_s1_r <= gate_i;
            gate_s2_r <= gate_s1_r;
            gate_s3_r <= gate_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // Input selection and gating
    // ------------------------------------------------------------------
    logic ext_rise;
    logic gate_fall;
    logic run_ok;
    logic int_tick;
    logic ext_tick;
    logic tick_raw;
    logic gate_event;

    assign ext_rise  = ext_s2_r && !ext_s3_r;
    assign gate_fall = gate_s3_r && !gate_s2_r;
    assign run_ok    = timer_run_bit_i && !(cpu_idle_i && stop_in_idle_i);

    // The internal clock and the synchronous counter both stop in sleep; only the
    // asynchronous counter keeps running there, since it needs no instruction clock.
    assign int_tick  = !clock_source_select_i && !cpu_sleep_i
                       && (!gate_accumulate_enable_i || gate_s2_r);
    assign ext_tick  = clock_source_select_i && ext_rise
                       && (!external_clock_sync_i || !cpu_sleep_i);
    assign tick_raw  = run_ok && (int_tick || ext_tick);

    assign gate_event = run_ok && !clock_source_select_i && gate_accumulate_enable_i
                        && gate_fall;

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    timer_ps_if ps_bus ();

    assign ps_bus.tick_in = tick_raw;
    assign ps_bus.sel     = prescale_select_i;
    assign ps_bus.clear   = count_wr_i || !timer_run_bit_i;

    timer_prescaler u_prescaler (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ps      (ps_bus.div)
    );

    // ------------------------------------------------------------------
    // Count, period and interrupt request
    // ------------------------------------------------------------------
    logic        tick;
    logic        match;
    logic [15:0] count_nxt;

    assign tick      = ps_bus.tick_out;
    assign match     = (timer_count_reg_o == timer_period_reg_o);
    assign count_nxt = match ? COUNT_RST : timer_count_reg_o + 16'h0001;

    // A software load wins over a tick in the same cycle.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timer_count_reg_o <= COUNT_RST;
        end else if (count_wr_i) begin
            timer_count_reg_o <= count_wdata_i;
        end else if (tick) begin
            timer_count_reg_o <= count_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timer_period_reg_o <= PERIOD_RST;
        end else if (period_wr_i) begin
            timer_period_reg_o <= period_wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= timer_irq_enable_i
                     && ((tick && match && !count_wr_i) || gate_event);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_priority_o <= PRIO_RST;
        end else begin
            irq_priority_o <= timer_irq_priority_i;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_HOLD_WHEN_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
        (!timer_run_bit_i && !count_wr_i) |=> $stable(timer_count_reg_o))
        else $error("Count moved while the run bit was clear.");

    AST_INCREMENT: assert property (@(posedge clock_i) disable iff (rst_i)
        (tick && !match && !count_wr_i) |=> (timer_count_reg_o == $past(timer_count_reg_o) + 16'h0001))
        else $error("Count did not step by one on a prescaled tick.");

    AST_WRAP: assert property (@(posedge clock_i) disable iff (rst_i)
        (tick && match && !count_wr_i) |=> (timer_count_reg_o == COUNT_RST))
        else $error("Count did not clear after matching the period.");

    AST_MATCH_IRQ: assert property (@(posedge clock_i) disable iff (rst_i)
        (tick && match && !count_wr_i && timer_irq_enable_i) |=> irq_o)
        else $error("Period match raised no interrupt request.");

    AST_GATE_IRQ: assert property (@(posedge clock_i) disable iff (rst_i)
        (timer_run_bit_i && !clock_source_select_i && gate_accumulate_enable_i && timer_irq_enable_i
         && !(cpu_idle_i && stop_in_idle_i) && gate_s3_r && !gate_s2_r) |=> irq_o)
        else $error("Gate falling edge raised no interrupt request.");

    AST_NO_IRQ_DISABLED: assert property (@(posedge clock_i) disable iff (rst_i)
        !timer_irq_enable_i |=> !irq_o)
        else $error("Interrupt request while the enable was clear.");

    AST_GATE_BLOCKS: assert property (@(posedge clock_i) disable iff (rst_i)
        (!clock_source_select_i && gate_accumulate_enable_i && !gate_s2_r) |-> !tick_raw)
        else $error("Internal clock counted while the gate was low.");

    AST_INTERNAL_RUNS: assert property (@(posedge clock_i) disable iff (rst_i)
        (timer_run_bit_i && !clock_source_select_i && !gate_accumulate_enable_i
         && !cpu_sleep_i && !cpu_idle_i) |-> tick_raw)
        else $error("Internal clock did not feed the prescaler.");

    AST_SYNC_SLEEP: assert property (@(posedge clock_i) disable iff (rst_i)
        (cpu_sleep_i && clock_source_select_i && external_clock_sync_i) |-> !tick_raw)
        else $error("Synchronous counter ran during sleep.");

    AST_ASYNC_SLEEP: assert property (@(posedge clock_i) disable iff (rst_i)
        (cpu_sleep_i && timer_run_bit_i && !cpu_idle_i && clock_source_select_i
         && !external_clock_sync_i && ext_s2_r && !ext_s3_r) |-> tick_raw)
        else $error("Asynchronous counter stopped during sleep.");

    AST_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
        count_wr_i |=> (timer_count_reg_o == $past(count_wdata_i)))
        else $error("Count write was not taken.");

    AST_LOAD_MASKS_MATCH: assert property (@(posedge clock_i) disable iff (rst_i)
        (count_wr_i && !gate_event) |=> !irq_o)
        else $error("Match interrupt raised in a cycle that loaded the count.");

    COV_MATCH_IRQ: cover property (@(posedge clock_i) disable iff (rst_i)
        tick && match && timer_irq_enable_i ##1 irq_o);
    COV_GATE_IRQ: cover property (@(posedge clock_i) disable iff (rst_i)
        gate_event && timer_irq_enable_i ##1 irq_o);
    COV_ASYNC_SLEEP: cover property (@(posedge clock_i) disable iff (rst_i)
        cpu_sleep_i && tick_raw);
    COV_LOAD_OVER_MATCH: cover property (@(posedge clock_i) disable iff (rst_i)
        count_wr_i && tick && match);

endmodule // gated_prescaled_timer16
`default_nettype wire

// >>> hw/timer_pkg.sv
package timer_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          COUNT_W    = 16;
    localparam int          PS_CNT_W   = 8;
    localparam int          PRIO_W     = 3;
    localparam logic [15:0] COUNT_RST  = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [2:0]  PRIO_RST   = 3'h0;

    // ------------------------------------------------------------------
    // Prescale selection and terminal counts
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_DIV1   = 2'h0,
        PS_DIV8   = 2'h1,
        PS_DIV64  = 2'h2,
        PS_DIV256 = 2'h3
    } prescale_t;

    localparam logic [7:0] PS_LAST_DIV1   = 8'h00;
    localparam logic [7:0] PS_LAST_DIV8   = 8'h07;
    localparam logic [7:0] PS_LAST_DIV64  = 8'h3f;
    localparam logic [7:0] PS_LAST_DIV256 = 8'hff;

    function automatic logic [7:0] ps_last(input prescale_t sel);
        case (sel)
            PS_DIV1:  ps_last = PS_LAST_DIV1;
            PS_DIV8:  ps_last = PS_LAST_DIV8;
            PS_DIV64: ps_last = PS_LAST_DIV64;
            default:  ps_last = PS_LAST_DIV256;
        endcase
    endfunction

endpackage

// >>> hw/timer_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
    input  wire logic clock_i,
    input  wire logic rst_i,
    timer_ps_if.div   ps
);
    import timer_pkg::*;

    logic [PS_CNT_W-1:0] div_cnt_r;
    logic                at_last;

    assign at_last     = (div_cnt_r == ps_last(ps.sel));
    assign ps.tick_out = ps.tick_in && at_last;

    // Clearing on a count write keeps the first period after a load whole.
    always_ff @(posedge clock_i) begin
        if (rst_i || ps.clear) begin
            div_cnt_r <= '0;
        end else if (ps.tick_in) begin
            div_cnt_r <= at_last ? '0 : div_cnt_r + 8'h01;
        end
    end

    AST_DIV1_PASS: assert property (@(posedge clock_i) disable iff (rst_i)
        (ps.sel == PS_DIV1) |-> (ps.tick_out == ps.tick_in))
        else $error("Divide-by-one prescale does not pass every tick.");

    AST_DIV8_SPACING: assert property (@(posedge clock_i) disable iff (rst_i)
        (ps.tick_out && ps.sel == PS_DIV8 && !ps.clear) ##1
        (ps.sel == PS_DIV8 && !ps.clear && ps.tick_in) [*7] |-> !ps.tick_out)
        else $error("Divide-by-eight prescale produced an early tick.");

endmodule // timer_prescaler
`default_nettype wire

// >>> hw/timer_ps_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer_ps_if;
    import timer_pkg::*;
    logic      tick_in;
    logic      clear;
    prescale_t sel;
    logic      tick_out;

    modport core (output tick_in, output clear, output sel, input tick_out);
    modport div  (input tick_in, input clear, input sel, output tick_out);
endinterface
`default_nettype wire

// >>> tb/ext_source.sv
`timescale 1ns/1ps
`default_nettype none
module ext_source (
    input  wire logic clock_i,
    input  wire logic run_i,
    input  wire logic gate_level_i,
    output logic      ext_clk_o,
    output logic      gate_o
);
    // The far clock stands still low outside a burst, like a gated crystal.
    // No initialiser: the first edge with the burst off clears the divider.
    logic [1:0] div_r;
    always_ff @(posedge clock_i) begin
        div_r <= run_i ? div_r + 2'h1 : 2'h0;
    end
    assign ext_clk_o = div_r[1];
    assign gate_o    = gate_level_i;
endmodule // ext_source
`default_nettype wire

// >>> tb/gated_prescaled_timer16_test.sv
`timescale 1ns/1ps
`default_nettype none
module gated_prescaled_timer16_test;
    import timer_pkg::*;
    logic        clock_i = 1'b0, rst_i = 1'b1, run = 1'b0, csel = 1'b0, gen = 1'b0, sync = 1'b0;
    logic        sidl = 1'b0, idle = 1'b0, sleep = 1'b0, ien = 1'b0, cwr = 1'b0, pwr = 1'b0;
    logic        ext_run = 1'b0, gate_lvl = 1'b0, irq;
    prescale_t   ps = PS_DIV1;
    logic [2:0]  prio = 3'h0, prio_o;
    logic [15:0] cdat = 16'h0000, pdat = 16'h0000, cnt, per, v;
    wire logic   ext_clk, gate;
    int          err_total = 0, comparisons = 0, n;

    always #12.5 clock_i = ~clock_i;

    ext_source PARTNER (.clock_i(clock_i), .run_i(ext_run), .gate_level_i(gate_lvl),
                        .ext_clk_o(ext_clk), .gate_o(gate));
    gated_prescaled_timer16 DUT (.clock_i(clock_i), .rst_i(rst_i), .timer_run_bit_i(run),
        .prescale_select_i(ps), .clock_source_select_i(csel), .gate_accumulate_enable_i(gen),
        .external_clock_sync_i(sync), .stop_in_idle_i(sidl), .cpu_idle_i(idle), .cpu_sleep_i(sleep),
        .timer_irq_enable_i(ien), .timer_irq_priority_i(prio), .count_wr_i(cwr), .count_wdata_i(cdat),
        .period_wr_i(pwr), .period_wdata_i(pdat), .ext_clk_i(ext_clk), .gate_i(gate),
        .timer_count_reg_o(cnt), .timer_period_reg_o(per), .irq_o(irq), .irq_priority_o(prio_o));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic give_verdict;
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic load(input logic [15:0] c, input logic [15:0] p);
        cdat = c; pdat = p; cwr = 1'b1; pwr = 1'b1;
        step(1);
        cwr = 1'b0; pwr = 1'b0;
        cmp(cnt, c, "count load");
        cmp(per, p, "period load");
    endtask
    // A bound that runs out ends the run, since later scenarios would be meaningless.
    task automatic wait_irq(input int bound, output int k);
        k = 0;
        while (irq !== 1'b1) begin
            if (k == bound) begin
                cmp(16'h0000, 16'h0001, "irq wait timed out");
                give_verdict();
            end
            step(1);
            k++;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        cmp(cnt, 16'h0000, "count reset");
        cmp(per, 16'hffff, "period reset");
        cmp({15'h0000, irq}, 16'h0000, "irq reset");
        cmp({13'h0000, prio_o}, 16'h0000, "priority reset");
    endtask
    task automatic t_walk;
        ien = 1'b1;
        load(16'h0000, 16'h0002);
        run = 1'b1;
        step(1); cmp(cnt, 16'h0001, "walk count 1");
        step(1); cmp(cnt, 16'h0002, "walk count 2");
        step(1); cmp(cnt, 16'h0000, "walk wrap");
        cmp({15'h0000, irq}, 16'h0001, "match irq");
        step(1); cmp({15'h0000, irq}, 16'h0000, "irq one cycle");
        run = 1'b0;
        v = cnt;
        step(5); cmp(cnt, v, "run low freezes");
    endtask
    task automatic t_prescale;
        for (int i = 0; i < 4; i++) begin
            n = (i == 3) ? 256 : (1 << (3 * i));
            ps = prescale_t'(i);
            prio = 3'(i + 3);
            load(16'h0000, 16'hffff);
            run = 1'b1;
            // Half a ratio of margin keeps the check clear of prescaler phase details.
            step(2 * n + n / 2);
            run = 1'b0;
            step(1);
            cmp(cnt, 16'h0002, "prescaled count");
            cmp({13'h0000, prio_o}, {13'h0000, prio}, "priority");
        end
        ps = PS_DIV1;
    endtask
    task automatic t_gate;
        gen = 1'b1; gate_lvl = 1'b1;
        load(16'h0000, 16'hffff);
        step(2);
        run = 1'b1;
        step(10); cmp(cnt, 16'h000a, "gated count");
        gate_lvl = 1'b0;
        wait_irq(6, n);
        cmp(16'(n), 16'h0003, "gate fall irq delay");
        v = cnt;
        step(6); cmp(cnt, v, "gate low holds");
        run = 1'b0; gen = 1'b0;
    endtask
    task automatic t_ext;
        csel = 1'b1; sync = 1'b1; ext_run = 1'b1;
        load(16'h0000, 16'hffff);
        run = 1'b1;
        step(40); cmp({15'h0000, cnt > 16'h0005}, 16'h0001, "sync ext counts");
        sleep = 1'b1; step(2); v = cnt;
        step(20); cmp(cnt, v, "sync ext stops in sleep");
        sync = 1'b0; step(2); v = cnt;
        step(20); cmp({15'h0000, cnt != v}, 16'h0001, "async ext runs in sleep");
        sleep = 1'b0; sidl = 1'b1; idle = 1'b1; step(2); v = cnt;
        step(20); cmp(cnt, v, "stop in idle");
        sidl = 1'b0;
        step(20); cmp({15'h0000, cnt != v}, 16'h0001, "runs in idle");
        idle = 1'b0; csel = 1'b0; ext_run = 1'b0; sleep = 1'b1; step(2); v = cnt;
        step(10); cmp(cnt, v, "internal stops in sleep");
        sleep = 1'b0; run = 1'b0;
    endtask
    task automatic t_mask;
        ien = 1'b0;
        load(16'h0000, 16'h0001);
        run = 1'b1;
        repeat (6) begin
            step(1); cmp({15'h0000, irq}, 16'h0000, "masked irq");
        end
        run = 1'b0;
    endtask
    // A count write in the cycle of a match wins and swallows that interrupt.
    task automatic t_load_wins;
        ien = 1'b1;
        load(16'h0000, 16'h0003);
        run = 1'b1;
        step(3); cmp(cnt, 16'h0003, "count at period");
        load(16'h0010, 16'h0003);
        cmp({15'h0000, irq}, 16'h0000, "load masks match irq");
        run = 1'b0;
    endtask
    task automatic t_reset_mid;
        load(16'h0005, 16'h0009);
        run = 1'b1;
        step(3); cmp(cnt, 16'h0008, "count before reset");
        rst_i = 1'b1; run = 1'b0;
        step(2);
        t_reset();
        rst_i = 1'b0;
        step(2); cmp(cnt, 16'h0000, "count idle after reset");
    endtask

    initial begin
        step(8);
        rst_i = 1'b0;
        step(1);
        t_reset();
        t_walk();
        t_prescale();
        t_gate();
        t_ext();
        t_mask();
        t_load_wins();
        t_reset_mid();
        give_verdict();
    end
endmodule // gated_prescaled_timer16_test
`default_nettype wire
